/* File: src/mpu_reset_supervisor_pkg.sv */
package mpu_reset_supervisor_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned PRESCALE_HZ = 1_000;
  // Prescaler divides the local clock down to a 1 ms tick.
  localparam int unsigned PRESCALE_CYCLES = CLK_HZ / PRESCALE_HZ;
  localparam int unsigned PRESCALE_W = 18;
  localparam int unsigned WATCHDOG_MS = 600;
  localparam int unsigned POWERUP_MS = 250;
  localparam int unsigned OVERRIDE_MS = 250;
  localparam int unsigned MS_W = 10;

  // ---------------------------------------------------------------------
  // Supervisor states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWERUP = 3'h1,
    ST_RUN = 3'h2,
    ST_HOLD = 3'h4
  } sup_state_t;

endpackage : mpu_reset_supervisor_pkg

/* File: src/ms_prescaler.sv */
`timescale 1ns/1ps
// Free-running divider that emits a one-cycle tick every DIV cycles.
// A clear restarts the count so a new interval starts aligned.
module ms_prescaler #(
  parameter int unsigned DIV = 200_000,
  parameter int unsigned W = 18
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control
  input wire logic clear,
  output logic tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count + W'(1);
    next_tick = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (count == W'(DIV - 1)) begin
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule : ms_prescaler

/* File: src/mpu_reset_supervisor.sv */
`timescale 1ns/1ps
module mpu_reset_supervisor #(
  parameter int unsigned PRESCALE_CYCLES =
    mpu_reset_supervisor_pkg::PRESCALE_CYCLES,
  parameter int unsigned WATCHDOG_MS = mpu_reset_supervisor_pkg::WATCHDOG_MS,
  parameter int unsigned POWERUP_MS = mpu_reset_supervisor_pkg::POWERUP_MS,
  parameter int unsigned OVERRIDE_MS = mpu_reset_supervisor_pkg::OVERRIDE_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Processor side
  input wire logic slow_peripheral_clock,
  input wire logic kickWrite,
  // Supply monitor and mailbox
  input wire logic powerFail,
  input wire logic mailboxReset,
  // Outputs to the processor
  output logic mpuReset_n,
  output logic mpuHalt_n,
  output logic kickArmed
);

  localparam int unsigned W = mpu_reset_supervisor_pkg::MS_W;

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic eclkPrev;
  logic eclkRise;
  logic kickSeen;
  logic mboxPrev;
  logic mboxRise;
  logic pfail;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
      eclkPrev <= 1'b0;
      mboxPrev <= 1'b0;
    end else begin
      syncA <= {slow_peripheral_clock, kickWrite, powerFail, mailboxReset};
      syncB <= syncA;
      eclkPrev <= syncB[3];
      mboxPrev <= syncB[0];
    end
  end

  assign eclkRise = syncB[3] & ~eclkPrev;
  assign kickSeen = syncB[2];
  assign pfail = syncB[1];
  assign mboxRise = syncB[0] & ~mboxPrev;

  // ---------------------------------------------------------------------
  // Millisecond prescaler
  // ---------------------------------------------------------------------
  logic msTick;
  logic clearPre;

  ms_prescaler #(
    .DIV(PRESCALE_CYCLES),
    .W(mpu_reset_supervisor_pkg::PRESCALE_W)
  ) u_pre (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clear(clearPre),
    .tick(msTick)
  );

  // ---------------------------------------------------------------------
  // Supervisor state
  // ---------------------------------------------------------------------
  mpu_reset_supervisor_pkg::sup_state_t state;
  mpu_reset_supervisor_pkg::sup_state_t next_state;
  logic [W-1:0] msCount;
  logic [W-1:0] next_msCount;
  logic next_kickArmed;
  logic next_resetOut;
  logic stimulus;
  logic holdTrigger;

  always_comb begin
    next_state = state;
    next_msCount = msCount;
    next_kickArmed = kickArmed;
    clearPre = 1'b0;
    stimulus = kickSeen | (eclkRise & ~kickArmed);
    holdTrigger = mboxRise | pfail;
    case (state)
      mpu_reset_supervisor_pkg::ST_POWERUP: begin
        next_kickArmed = 1'b0;
        if (holdTrigger) begin
          next_msCount = '0;
          clearPre = 1'b1;
        end else if (msCount >= W'(POWERUP_MS)) begin
          next_state = mpu_reset_supervisor_pkg::ST_RUN;
          next_msCount = '0;
          clearPre = 1'b1;
        end else if (msTick) begin
          next_msCount = msCount + W'(1);
        end
      end
      mpu_reset_supervisor_pkg::ST_RUN: begin
        if (kickSeen) begin
          next_kickArmed = 1'b1;
        end
        if (holdTrigger) begin
          next_state = mpu_reset_supervisor_pkg::ST_HOLD;
          next_msCount = '0;
          clearPre = 1'b1;
        end else if (stimulus) begin
          next_msCount = '0;
          clearPre = 1'b1;
        end else if (msCount >= W'(WATCHDOG_MS)) begin
          next_state = mpu_reset_supervisor_pkg::ST_HOLD;
          next_msCount = '0;
          clearPre = 1'b1;
        end else if (msTick) begin
          next_msCount = msCount + W'(1);
        end
      end
      mpu_reset_supervisor_pkg::ST_HOLD: begin
        next_kickArmed = 1'b0;
        if (holdTrigger) begin
          next_msCount = '0;
          clearPre = 1'b1;
        end else if (msCount >= W'(OVERRIDE_MS)) begin
          next_state = mpu_reset_supervisor_pkg::ST_RUN;
          next_msCount = '0;
          clearPre = 1'b1;
        end else if (msTick) begin
          next_msCount = msCount + W'(1);
        end
      end
      default: begin
        next_state = mpu_reset_supervisor_pkg::ST_POWERUP;
        next_msCount = '0;
      end
    endcase
    next_resetOut = (next_state != mpu_reset_supervisor_pkg::ST_RUN);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= mpu_reset_supervisor_pkg::ST_POWERUP;
      msCount <= '0;
      kickArmed <= 1'b0;
      mpuReset_n <= 1'b0;
      mpuHalt_n <= 1'b0;
    end else begin
      state <= next_state;
      msCount <= next_msCount;
      kickArmed <= next_kickArmed;
      mpuReset_n <= ~next_resetOut;
      mpuHalt_n <= ~next_resetOut;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  AST_TIMEOUT: assert property (
    (state == mpu_reset_supervisor_pkg::ST_RUN && msCount >= W'(WATCHDOG_MS)
     && !stimulus && !holdTrigger) |=> !mpuReset_n
  ) else $error("Watchdog expiry did not assert reset.");

  AST_SLOW_PERIPHERAL_CLOCK_FEED: assert property (
    (state == mpu_reset_supervisor_pkg::ST_RUN && !kickArmed && eclkRise
     && !holdTrigger) |=> (msCount == '0 && mpuReset_n)
  ) else $error("Slow clock pulse did not restart the watchdog.");

  AST_ARM: assert property (
    (state == mpu_reset_supervisor_pkg::ST_RUN && kickSeen && !holdTrigger)
    |=> kickArmed
  ) else $error("First kick did not disarm slow clock feed.");

  AST_NO_SLOW_PERIPHERAL_CLOCK: assert property (
    (state == mpu_reset_supervisor_pkg::ST_RUN && kickArmed && eclkRise
     && !kickSeen && !holdTrigger && msTick && msCount < W'(WATCHDOG_MS))
    |=> msCount == $past(msCount) + W'(1)
  ) else $error("Slow clock still fed the watchdog after a kick.");

  AST_POWERUP: assert property (
    (state == mpu_reset_supervisor_pkg::ST_POWERUP && msCount < W'(POWERUP_MS))
    |=> !mpuReset_n && !mpuHalt_n
  ) else $error("Reset released before power-up interval.");

  AST_PFAIL: assert property (
    pfail |=> !mpuReset_n && !mpuHalt_n
  ) else $error("Power fail did not hold reset.");

  AST_MAILBOX: assert property (
    (mboxRise && !pfail) |=> (!mpuReset_n && msCount == '0)
  ) else $error("Mailbox write did not start a reset hold.");

  AST_PAIR: assert property (
    mpuReset_n == mpuHalt_n
  ) else $error("Reset and halt disagree.");

  AST_PRE_CLEAR: assert property (
    clearPre |=> !msTick
  ) else $error("Prescaler not restarted by a new trigger.");

  COV_RELEASE: cover property (!mpuReset_n ##1 mpuReset_n);
  COV_TIMEOUT: cover property (
    state == mpu_reset_supervisor_pkg::ST_RUN ##1
    state == mpu_reset_supervisor_pkg::ST_HOLD);
  COV_ARMED: cover property (!kickArmed ##1 kickArmed);
  COV_MAILBOX: cover property (mboxRise && mpuReset_n);

endmodule : mpu_reset_supervisor

/* File: dv/proc_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Processor model: slow clock and periodic kick writes.
// ---------------------------------------------------------------------
module proc_model (
  // Clock
  input wire logic sys_clk,
  // Control from the bench
  input wire logic kickEn,
  input wire logic [4:0] kickGap,
  input wire logic mpuReset_n,
  // Processor outputs
  output logic slow_peripheral_clock,
  output logic kickWrite
);
  logic [2:0] div = 3'h0;
  logic [4:0] cnt = 5'h00;
  assign slow_peripheral_clock = div[2];
  always @(posedge sys_clk) begin
    div <= div + 3'h1;
    cnt <= cnt + 5'h01;
    kickWrite <= 1'b0;
    // A held processor makes no kick writes.
    if (kickEn && mpuReset_n && cnt >= kickGap) begin
      kickWrite <= 1'b1;
      cnt <= 5'h00;
    end
  end
endmodule : proc_model

/* File: dv/test_mpu_reset_supervisor.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_mpu_reset_supervisor;
  localparam int PS = 4;
  localparam int WD = 6;
  localparam int OV = 3;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic powerFail = 1'b0;
  logic mailboxReset = 1'b0;
  logic kickEn = 1'b0;
  logic [4:0] kickGap = 5'h04;
  logic spc, kickWrite, mpuReset_n, mpuHalt_n, kickArmed;
  int miscompares = 0;
  int nTests = 0;
  int n;
  logic [31:0] seed = 32'd38603;
  always #2.5 sys_clk = ~sys_clk;
  proc_model cpu (.sys_clk(sys_clk), .kickEn(kickEn), .kickGap(kickGap),
    .mpuReset_n(mpuReset_n), .slow_peripheral_clock(spc),
    .kickWrite(kickWrite));
  mpu_reset_supervisor #(.PRESCALE_CYCLES(PS), .WATCHDOG_MS(WD),
    .POWERUP_MS(3), .OVERRIDE_MS(OV)) uut (.sys_clk(sys_clk),
    .arst_n(arst_n), .slow_peripheral_clock(spc), .kickWrite(kickWrite),
    .powerFail(powerFail), .mailboxReset(mailboxReset),
    .mpuReset_n(mpuReset_n), .mpuHalt_n(mpuHalt_n), .kickArmed(kickArmed));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic results;
    $display("tests=%0d mismatches=%0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // Counts cycles until reset reaches a level; a hang ends the run.
  task automatic waitFor(input logic v, input int lim, output int k);
    k = 0;
    while (mpuReset_n !== v) begin
      @(posedge sys_clk);
      k++;
      if (k >= lim) begin
        miscompares++;
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, mpuReset_n, v);
        results();
      end
    end
  endtask : waitFor
  task automatic pulseMailbox;
    mailboxReset <= 1'b1;
    @(posedge sys_clk);
    mailboxReset <= 1'b0;
  endtask : pulseMailbox
  always @(negedge sys_clk) begin
    if (arst_n) `CHK(mpuHalt_n, mpuReset_n)
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    waitFor(1'b1, 200, n);
    `CHK(n >= 3 * PS, 1'b1)
    $display("power-up done");
    repeat (100) @(posedge sys_clk);
    `CHK(mpuReset_n, 1'b1)
    `CHK(kickArmed, 1'b0)
    $display("slow clock feed done");
    kickEn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      kickGap <= 5'(4 + seed % 16);
      repeat (20) @(posedge sys_clk);
      `CHK(mpuReset_n, 1'b1)
    end
    `CHK(kickArmed, 1'b1)
    // Stop kicking right after a kick so the expiry is timed from it.
    n = 0;
    while (kickWrite !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(kickWrite, 1'b1)
    kickEn <= 1'b0;
    @(posedge sys_clk);
    waitFor(1'b0, 80, n);
    `CHK(n >= WD * PS, 1'b1)
    `CHK(n <= (WD + 1) * PS + 4, 1'b1)
    waitFor(1'b1, 80, n);
    `CHK(n >= OV * PS, 1'b1)
    `CHK(kickArmed, 1'b0)
    $display("watchdog expiry done");
    powerFail <= 1'b1;
    waitFor(1'b0, 8, n);
    repeat (60) @(posedge sys_clk);
    `CHK(mpuReset_n, 1'b0)
    powerFail <= 1'b0;
    waitFor(1'b1, 80, n);
    `CHK(n >= OV * PS, 1'b1)
    $display("power fail done");
    for (int r = 0; r < 2; r++) begin
      repeat (10) @(posedge sys_clk);
      pulseMailbox();
      waitFor(1'b0, 8, n);
      if (r == 1) begin
        repeat (8) @(posedge sys_clk);
        pulseMailbox();
      end
      waitFor(1'b1, 80, n);
      `CHK(n >= OV * PS - 4, 1'b1)
      if (r == 1) `CHK(n >= OV * PS, 1'b1)
    end
    $display("mailbox done");
    results();
  end
endmodule : test_mpu_reset_supervisor
